// ---- rtl/uartx_tx_sync.sv ----
`timescale 1ns/1ps
`include "uartx_regs.svh"
// Notes on behaviour
// (RL1) single-clock or dual-clock build option
// (RL2) dual build routes all crossings through synchroniser
// (RL3) start begins transfer and sets busy
// (RL4) start while busy stores pending word
// (RL5) busy clears once word delivered
// (RL6) single build passes signals straight through
// (RL7) data crossings use full request/acknowledge handshake
// (RL8) level crossings use two destination flops
// (RL9) config seen, machines reset within eight cycles
// (RL10) host waits settling time before traffic
// (RL11) queued characters go out back to back
// (RL12) query starts one baud clock before stop end
// (RL13) dual query latency four slow plus four bus
// (RL14) long latency inserts idle before next start
// (RL15) baud period is divisor times slow clock
// (RL16) idle gap at most latency plus fifteen bauds
// (RL17) sixteen baud clocks per state, eight half stop
// (RL18) finish flag one baud early, synced to bus
// (RL19) bus requests next character one cycle later
// (RL20) request clears counter, start after sixteen
// (RL21) single build query latency one bus cycle
// (RL22) integrator limits slow clock to bus ratio
// (RL23) source word held until acknowledge returns
module uartx_tx_sync #(
    parameter int CLOCK_MODE = `UARTX_MODE_DUAL // [RL1]
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SCLK_PIN,
    input wire logic CFG_WRITE,
    input wire uartx_pkg::uartx_byte_t DIVISOR_HIGH_BYTE,
    input wire uartx_pkg::uartx_byte_t DIVISOR_LOW_BYTE,
    input wire logic HALF_STOP,
    input wire logic FIFO_VALID,
    input wire uartx_pkg::uartx_byte_t FIFO_DATA,
    output logic FIFO_POP,
    output logic SOUT,
    output logic TX_ACTIVE,
    output logic CFG_SETTLED
);
    import uartx_pkg::*;

    localparam bit DUAL = (CLOCK_MODE == `UARTX_MODE_DUAL);

    uartx_hs_if hs ();

    logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg, sclk_en;
    logic cfg_tog_reg, ready_reg, fin_prev_reg, fin_sync, take;
    logic [`UARTX_LVL_W-1:0] lvl_src, lvl_dst;
    logic b_seen_reg, cfg_ack, fin_tog_reg, fin_bus, go_reg;
    uartx_div_t div, div_cnt_reg;
    logic bclk_en, last_bclk, fin_point, cfg_chg;
    uartx_tx_state_t state_reg;
    logic [3:0] bcnt_reg;
    logic [2:0] bitn_reg;
    uartx_byte_t shift_reg;

    // slow clock pin: two flops, then rising-edge enable
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_s3_reg <= 1'b0;
        end else begin
            sclk_s1_reg <= SCLK_PIN;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
        end
    end
    assign sclk_en = DUAL ? (sclk_s2_reg & ~sclk_s3_reg) : 1'b1; // [RL1]

    // word crossing from bus domain into baud domain
    uartx_data_sync #(.CLOCK_MODE(CLOCK_MODE), .PENDING(1'b1)) u_data_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .dst_en(sclk_en),
        .hs(hs.sync) // [RL2]
    );

    // bus side: config toggle marks each write
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cfg_tog_reg <= 1'b0;
        end else if (CFG_WRITE) begin
            cfg_tog_reg <= ~cfg_tog_reg;
        end
    end

    // level crossings of config into the baud domain
    assign lvl_src = {HALF_STOP, DIVISOR_HIGH_BYTE, DIVISOR_LOW_BYTE, cfg_tog_reg};
    genvar gi;
    generate
        for (gi = 0; gi < `UARTX_LVL_W; gi = gi + 1) begin : g_lvl
            if (DUAL) begin : g_two
                logic s1_reg, s2_reg;
                always_ff @(posedge CLK) begin
                    if (!RST_N) begin
                        s1_reg <= 1'b0;
                        s2_reg <= 1'b0;
                    end else if (sclk_en) begin
                        s1_reg <= lvl_src[gi]; // [RL8]
                        s2_reg <= s1_reg; // [RL8]
                    end
                end
                assign lvl_dst[gi] = s2_reg;
            end else begin : g_wire
                assign lvl_dst[gi] = lvl_src[gi]; // [RL6]
            end
        end
        // baud-domain flags back into the bus domain
        if (DUAL) begin : g_back
            logic ack_s1_reg, ack_s2_reg, fin_s1_reg, fin_s2_reg;
            always_ff @(posedge CLK) begin
                if (!RST_N) begin
                    ack_s1_reg <= 1'b0;
                    ack_s2_reg <= 1'b0;
                    fin_s1_reg <= 1'b0;
                    fin_s2_reg <= 1'b0;
                end else begin
                    ack_s1_reg <= b_seen_reg; // [RL8]
                    ack_s2_reg <= ack_s1_reg;
                    fin_s1_reg <= fin_tog_reg; // [RL18]
                    fin_s2_reg <= fin_s1_reg;
                end
            end
            assign cfg_ack = ack_s2_reg;
            assign fin_bus = fin_s2_reg;
        end else begin : g_back_wire
            assign cfg_ack = b_seen_reg; // [RL6]
            assign fin_bus = fin_tog_reg; // [RL21]
        end
    endgenerate

    assign div = {lvl_dst[`UARTX_LVL_DIV_HI:`UARTX_LVL_DIV_LO+8], lvl_dst[`UARTX_LVL_DIV_LO+7:`UARTX_LVL_DIV_LO]};
    assign cfg_chg = lvl_dst[`UARTX_LVL_TOG] ^ b_seen_reg;

    // bus side: settled flag, finished edge and next-character request
    assign fin_sync = fin_bus ^ fin_prev_reg;
    assign take = ready_reg && FIFO_VALID && !hs.busy;
    assign hs.start = take; // [RL19]
    assign hs.data = FIFO_DATA;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            fin_prev_reg <= 1'b0;
            ready_reg <= 1'b1;
            FIFO_POP <= 1'b0;
            CFG_SETTLED <= 1'b0;
        end else begin
            fin_prev_reg <= fin_bus;
            FIFO_POP <= take;
            CFG_SETTLED <= (cfg_ack == cfg_tog_reg); // [RL9]
            if (fin_sync || CFG_WRITE) begin
                ready_reg <= 1'b1; // [RL19]
            end else if (take) begin
                ready_reg <= 1'b0;
            end
        end
    end

    // baud clock: one pulse per divisor slow cycles
    assign bclk_en = sclk_en && (div != `UARTX_DIV_ZERO) && (div_cnt_reg == div - `UARTX_DIV_ONE); // [RL15]
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            div_cnt_reg <= `UARTX_DIV_ZERO;
        end else if (sclk_en) begin
            if (cfg_chg || bclk_en || div_cnt_reg >= div) begin
                div_cnt_reg <= `UARTX_DIV_ZERO;
            end else begin
                div_cnt_reg <= div_cnt_reg + `UARTX_DIV_ONE; // [RL15]
            end
        end
    end

    // end of a state's baud count, finish point one baud clock earlier
    always_comb begin
        last_bclk = (state_reg == TX_HALF) ? (bcnt_reg == `UARTX_HALF_LAST) : (bcnt_reg == `UARTX_OVS_LAST);
        fin_point = 1'b0;
        if (state_reg == TX_HALF) begin
            fin_point = (bcnt_reg == `UARTX_FIN_HALF); // [RL17]
        end else if (state_reg == TX_STOP && !lvl_dst[`UARTX_LVL_HALF]) begin
            fin_point = (bcnt_reg == `UARTX_FIN_FULL); // [RL12]
        end
    end

    // baud-domain config acknowledge and finished toggle
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            b_seen_reg <= 1'b0;
            fin_tog_reg <= 1'b0;
        end else if (sclk_en) begin
            b_seen_reg <= lvl_dst[`UARTX_LVL_TOG]; // [RL9]
            // query round trip: this toggle, back sync, request, forward sync
            if (bclk_en && fin_point && !cfg_chg) begin
                fin_tog_reg <= ~fin_tog_reg; // [RL18] [RL12] [RL13]
            end
        end
    end

    // transmit state machine, advanced on baud clocks
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_reg <= TX_IDLE;
            bcnt_reg <= `UARTX_CNT_ZERO;
            bitn_reg <= `UARTX_BIT_ZERO;
            shift_reg <= 8'h00;
            go_reg <= 1'b0;
        end else if (sclk_en && cfg_chg) begin
            state_reg <= TX_IDLE; // [RL9]
            bcnt_reg <= `UARTX_CNT_ZERO;
            go_reg <= 1'b0;
        end else if (sclk_en) begin
            if (hs.dst_valid) begin
                shift_reg <= hs.dst_data;
            end
            if (hs.dst_valid && state_reg == TX_IDLE) begin
                state_reg <= TX_WAIT; // [RL14]
                bcnt_reg <= `UARTX_CNT_ZERO; // [RL20]
            end else if (hs.dst_valid && (state_reg == TX_STOP || state_reg == TX_HALF)) begin
                go_reg <= 1'b1; // [RL11]
            end
            if (bclk_en && state_reg != TX_IDLE && !(hs.dst_valid && state_reg == TX_IDLE)) begin
                bcnt_reg <= last_bclk ? `UARTX_CNT_ZERO : bcnt_reg + 4'h1; // [RL17]
                if (last_bclk) begin
                    case (state_reg)
                        TX_WAIT: begin
                            state_reg <= TX_START; // [RL20]
                        end
                        TX_START: begin
                            state_reg <= TX_DATA;
                            bitn_reg <= `UARTX_BIT_ZERO;
                        end
                        TX_DATA: begin
                            shift_reg <= {1'b0, shift_reg[7:1]};
                            bitn_reg <= bitn_reg + 3'h1;
                            if (bitn_reg == `UARTX_BIT_LAST) begin
                                state_reg <= TX_STOP;
                            end
                        end
                        TX_STOP, TX_HALF: begin
                            if (state_reg == TX_STOP && lvl_dst[`UARTX_LVL_HALF]) begin
                                state_reg <= TX_HALF; // [RL17]
                            end else if (go_reg || hs.dst_valid) begin
                                state_reg <= TX_START; // [RL11]
                                go_reg <= 1'b0;
                            end else begin
                                state_reg <= TX_IDLE; // [RL17] [RL14] [RL16]
                            end
                        end
                        default: begin
                            state_reg <= TX_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // serial output and activity flag
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            SOUT <= 1'b1;
            TX_ACTIVE <= 1'b0;
        end else begin
            SOUT <= (state_reg == TX_START) ? 1'b0 : (state_reg == TX_DATA) ? shift_reg[0] : 1'b1; // [RL20]
            TX_ACTIVE <= (state_reg != TX_IDLE);
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_start_low: assert property (state_reg == TX_START |=> !SOUT) // [RL20]
        else $error("start state did not drive the line low");
    a_stop_high: assert property (state_reg == TX_STOP |=> SOUT) // [RL17]
        else $error("stop state did not hold the line high");
    a_wait_cleared: assert property ((sclk_en && !cfg_chg && hs.dst_valid && state_reg == TX_IDLE) // [RL20]
        |=> state_reg == TX_WAIT && bcnt_reg == `UARTX_CNT_ZERO)
        else $error("request did not clear the baud count");
    a_start_count: assert property (($past(state_reg) == TX_START && state_reg == TX_DATA) // [RL17]
        |-> $past(bcnt_reg) == `UARTX_OVS_LAST)
        else $error("start bit length not sixteen baud clocks");
    a_finish_stop: assert property ($changed(fin_tog_reg) // [RL18]
        |-> ($past(state_reg) == TX_STOP || $past(state_reg) == TX_HALF))
        else $error("finish flag outside stop");
    a_next_request: assert property ((ready_reg && FIFO_VALID && !hs.busy) |=> FIFO_POP ##1 !FIFO_POP) // [RL19]
        else $error("next character not requested");
    a_cfg_reset: assert property ((sclk_en && cfg_chg) |=> state_reg == TX_IDLE && !go_reg) // [RL9]
        else $error("config change did not reset the transmitter");
    a_cfg_pending: assert property (CFG_WRITE |=> ##1 !CFG_SETTLED) // [RL9]
        else $error("settled flag stayed high after a config write");
endmodule : uartx_tx_sync

// ---- rtl/uartx_regs.svh ----
`ifndef UARTX_REGS_SVH
`define UARTX_REGS_SVH

// build modes
`define UARTX_MODE_SINGLE 1
`define UARTX_MODE_DUAL 2

// baud divisor
`define UARTX_DIV_ZERO 16'h0000
`define UARTX_DIV_ONE 16'h0001

// oversampling counter: full bit, half stop bit, finish point one baud clock early
`define UARTX_CNT_ZERO 4'h0
`define UARTX_OVS_LAST 4'hF
`define UARTX_HALF_LAST 4'h7
`define UARTX_FIN_FULL 4'hE
`define UARTX_FIN_HALF 4'h6

// data bits per character
`define UARTX_BIT_ZERO 3'h0
`define UARTX_BIT_LAST 3'h7

// level-synchronised config vector: {half stop, divisor high, divisor low, config toggle}
`define UARTX_LVL_W 18
`define UARTX_LVL_TOG 0
`define UARTX_LVL_DIV_LO 1
`define UARTX_LVL_DIV_HI 16
`define UARTX_LVL_HALF 17

`endif

// ---- rtl/uartx_pkg.sv ----
package uartx_pkg;
    typedef logic [7:0] uartx_byte_t;
    typedef logic [15:0] uartx_div_t;
    typedef enum logic [2:0] {
        TX_IDLE,
        TX_WAIT,
        TX_START,
        TX_DATA,
        TX_STOP,
        TX_HALF
    } uartx_tx_state_t;
endpackage : uartx_pkg

// ---- rtl/uartx_hs_if.sv ----
`timescale 1ns/1ps
// word handshake between the bus-domain feeder and the data synchroniser
interface uartx_hs_if;
    import uartx_pkg::*;
    logic start;
    uartx_byte_t data;
    logic busy;
    logic dst_valid;
    uartx_byte_t dst_data;
    modport user (output start, output data, input busy, input dst_valid, input dst_data);
    modport sync (input start, input data, output busy, output dst_valid, output dst_data);
endinterface : uartx_hs_if

// ---- rtl/uartx_data_sync.sv ----
`timescale 1ns/1ps
`include "uartx_regs.svh"
module uartx_data_sync #(
    parameter int CLOCK_MODE = `UARTX_MODE_DUAL,
    parameter bit PENDING = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic dst_en,
    uartx_hs_if.sync hs
);
    import uartx_pkg::*;

    generate
        if (CLOCK_MODE == `UARTX_MODE_SINGLE) begin : g_pass
            // no synchronising logic, straight through
            assign hs.busy = 1'b0; // [RL6]
            assign hs.dst_valid = hs.start; // [RL6]
            assign hs.dst_data = hs.data; // [RL6]
        end else begin : g_sync
            logic req_reg, busy_reg, pend_valid_reg;
            logic ack_s1_reg, ack_s2_reg;
            logic req_s1_reg, req_s2_reg, seen_reg, dst_valid_reg;
            uartx_byte_t hold_reg, pend_reg, dst_data_reg;
            logic done;

            assign done = busy_reg && (ack_s2_reg == req_reg);

            // source side: request toggle, held word and optional pending slot
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    req_reg <= 1'b0;
                    busy_reg <= 1'b0;
                    pend_valid_reg <= 1'b0;
                    hold_reg <= 8'h00;
                    pend_reg <= 8'h00;
                end else if (!busy_reg) begin
                    if (hs.start) begin
                        hold_reg <= hs.data; // [RL23]
                        req_reg <= ~req_reg; // [RL3] [RL7]
                        busy_reg <= 1'b1; // [RL3]
                    end
                end else if (done) begin
                    if (pend_valid_reg) begin
                        hold_reg <= pend_reg; // [RL4]
                        req_reg <= ~req_reg; // [RL4]
                        pend_valid_reg <= hs.start;
                        if (hs.start) begin
                            pend_reg <= hs.data;
                        end
                    end else if (hs.start) begin
                        hold_reg <= hs.data;
                        req_reg <= ~req_reg;
                    end else begin
                        busy_reg <= 1'b0; // [RL5]
                    end
                end else if (hs.start && PENDING) begin
                    pend_reg <= hs.data; // [RL4]
                    pend_valid_reg <= 1'b1; // [RL4]
                end
            end

            // acknowledge back into the source domain
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    ack_s1_reg <= 1'b0;
                    ack_s2_reg <= 1'b0;
                end else begin
                    ack_s1_reg <= seen_reg; // [RL7]
                    ack_s2_reg <= ack_s1_reg;
                end
            end

            // destination side, advanced on destination clock enables
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    req_s1_reg <= 1'b0;
                    req_s2_reg <= 1'b0;
                    seen_reg <= 1'b0;
                    dst_valid_reg <= 1'b0;
                    dst_data_reg <= 8'h00;
                end else if (dst_en) begin
                    req_s1_reg <= req_reg; // [RL7]
                    req_s2_reg <= req_s1_reg;
                    seen_reg <= req_s2_reg;
                    dst_valid_reg <= req_s2_reg ^ seen_reg;
                    if (req_s2_reg ^ seen_reg) begin
                        dst_data_reg <= hold_reg; // [RL23]
                    end
                end
            end

            assign hs.busy = busy_reg;
            assign hs.dst_valid = dst_valid_reg;
            assign hs.dst_data = dst_data_reg;

            a_busy_on_start: assert property (@(posedge clk) disable iff (!rst_n) // [RL3]
                (hs.start && !busy_reg) |=> busy_reg)
                else $error("busy not set after start");
            a_hold_stable: assert property (@(posedge clk) disable iff (!rst_n) // [RL23]
                (busy_reg && !done) |=> $stable(hold_reg))
                else $error("held word changed during transfer");
        end
    endgenerate
endmodule : uartx_data_sync

// ---- testbench/uartx_fifo_model.sv ----
`timescale 1ns/1ps
// bus-domain transmit queue standing on the far side of the crossing
module uartx_fifo_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fifo_pop,
    output logic fifo_valid,
    output uartx_pkg::uartx_byte_t fifo_data
);
    import uartx_pkg::*;
    uartx_byte_t q[$];
    uartx_byte_t last;
    logic pop_seen;
    int pops;
    initial begin
        fifo_valid = 1'b0;
        fifo_data = 8'h00;
        last = 8'h00;
        pops = 0;
    end
    // entries join the tail in write order
    task automatic push(input uartx_byte_t b);
        q.push_back(b);
    endtask : push
    // pop after the design's pulse; an empty head shows scrambled data, not the old word
    always @(posedge clk) begin
        pop_seen = (rst_n === 1'b1) && (fifo_pop === 1'b1);
        #2;
        if (pop_seen && q.size() > 0) begin
            last = q.pop_front();
            pops++;
        end
        fifo_valid = (q.size() > 0);
        fifo_data = (q.size() > 0) ? q[0] : ~last;
    end
endmodule : uartx_fifo_model

// ---- testbench/uartx_tx_sync_bench.sv ----
`timescale 1ns/1ps
module uartx_tx_sync_bench;
    import uartx_pkg::*;
    logic clk = 1'b0;
    logic sclk = 1'b0;
    logic rst_n, cfg_write, half_stop, fifo_valid, fifo_pop, sout, tx_active, cfg_settled;
    uartx_byte_t div_hi, div_lo, fifo_data;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;

    uartx_tx_sync #(.CLOCK_MODE(2)) uartx_tx_sync_inst (.CLK(clk), .RST_N(rst_n), .SCLK_PIN(sclk),
        .CFG_WRITE(cfg_write), .DIVISOR_HIGH_BYTE(div_hi), .DIVISOR_LOW_BYTE(div_lo),
        .HALF_STOP(half_stop), .FIFO_VALID(fifo_valid), .FIFO_DATA(fifo_data), .FIFO_POP(fifo_pop),
        .SOUT(sout), .TX_ACTIVE(tx_active), .CFG_SETTLED(cfg_settled));
    uartx_fifo_model uartx_fifo_model_inst (.clk(clk), .rst_n(rst_n), .fifo_pop(fifo_pop),
        .fifo_valid(fifo_valid), .fifo_data(fifo_data));

    // bus clock 100 MHz; baud-domain clock 37 ns, well under half the bus rate
    always #5 clk = ~clk;
    always #18.5 sclk = ~sclk;
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            test_done();
        end
    end

    task automatic test_done();
        if (err_total == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    task automatic chk1(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1
    task automatic chk8(input string what, input uartx_byte_t exp, input uartx_byte_t got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8
    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        compares++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_rng
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic slow(input int n);
        repeat (n) @(posedge sclk);
    endtask : slow
    // write config, then wait for the baud side to settle before any traffic
    task automatic cfg(input uartx_div_t div, input logic half);
        int n;
        tick(1);
        div_hi = div[15:8];
        div_lo = div[7:0];
        half_stop = half;
        tick(1);
        cfg_write = 1'b1;
        tick(1);
        cfg_write = 1'b0;
        tick(2);
        chk1("cfg_settled drop", 1'b0, cfg_settled);
        n = 0;
        while (cfg_settled !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk_rng("settle cycles", 0, 30, n);
    endtask : cfg
    // decode one frame from its falling edge; returns at mid stop bit
    task automatic rx_char(input int div, input uartx_byte_t exp);
        int n;
        uartx_byte_t got;
        n = 0;
        while (sout !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk_rng("start wait", 0, 2999, n);
        slow(8 * div);
        chk1("start bit", 1'b0, sout);
        chk1("tx_active", 1'b1, tx_active);
        for (int i = 0; i < 8; i++) begin
            slow(16 * div);
            got[i] = sout;
        end
        chk8("data lsb first", exp, got);
        slow(16 * div);
        chk1("stop bit", 1'b1, sout);
    endtask : rx_char
    // baud-domain cycles until the line falls again
    task automatic high_len(output int n);
        n = 0;
        while (sout !== 1'b0 && n < 200) begin
            @(posedge sclk);
            n++;
        end
    endtask : high_len
    task automatic wait_idle();
        int n;
        n = 0;
        while (tx_active !== 1'b0 && n < 2000) begin
            tick(1);
            n++;
        end
        chk_rng("idle wait", 0, 200, n);
        chk1("line idle", 1'b1, sout);
    endtask : wait_idle

    task automatic t_reset();
        repeat (5) @(posedge clk);
        #1;
        chk1("reset sout", 1'b1, sout);
        chk1("reset pop", 1'b0, fifo_pop);
        chk1("reset active", 1'b0, tx_active);
        chk1("reset settled", 1'b0, cfg_settled);
        rst_n = 1'b1;
        tick(1);
        chk1("settled after reset", 1'b1, cfg_settled);
    endtask : t_reset
    task automatic t_single();
        cfg(16'h0001, 1'b0);
        uartx_fifo_model_inst.push(8'hA5);
        rx_char(1, 8'hA5);
        wait_idle();
        chk_rng("pops one", 1, 1, uartx_fifo_model_inst.pops);
    endtask : t_single
    // three queued words; gap from mid stop to next start is bounded
    task automatic t_b2b();
        int n;
        uartx_fifo_model_inst.push(8'h3C);
        uartx_fifo_model_inst.push(8'hC3);
        uartx_fifo_model_inst.push(8'h81);
        rx_char(1, 8'h3C);
        high_len(n);
        chk_rng("gap one", 7, 31, n);
        rx_char(1, 8'hC3);
        high_len(n);
        chk_rng("gap two", 7, 31, n);
        rx_char(1, 8'h81);
        wait_idle();
        chk_rng("pops four", 4, 4, uartx_fifo_model_inst.pops);
        chk1("fifo drained", 1'b0, fifo_valid);
    endtask : t_b2b
    task automatic t_div2();
        cfg(16'h0002, 1'b0);
        uartx_fifo_model_inst.push(8'h5A);
        rx_char(2, 8'h5A);
        wait_idle();
    endtask : t_div2
    // half stop adds eight baud clocks to the stop time
    task automatic t_half();
        int n;
        cfg(16'h0001, 1'b1);
        uartx_fifo_model_inst.push(8'h0F);
        uartx_fifo_model_inst.push(8'hF0);
        rx_char(1, 8'h0F);
        high_len(n);
        chk_rng("half stop gap", 15, 39, n);
        rx_char(1, 8'hF0);
        wait_idle();
    endtask : t_half
    // config rewrite in mid frame drops the frame
    task automatic t_abort();
        int n;
        uartx_fifo_model_inst.push(8'h00);
        n = 0;
        while (sout !== 1'b0 && n < 3000) begin
            tick(1);
            n++;
        end
        slow(40);
        chk1("low in frame", 1'b0, sout);
        cfg(16'h0001, 1'b0);
        tick(10);
        chk1("abort sout", 1'b1, sout);
        chk1("abort active", 1'b0, tx_active);
        tick(300);
        chk1("no restart", 1'b1, sout);
    endtask : t_abort

    initial begin
        rst_n = 1'b0;
        cfg_write = 1'b0;
        half_stop = 1'b0;
        div_hi = 8'h00;
        div_lo = 8'h01;
        t_reset();
        t_single();
        t_b2b();
        t_div2();
        t_half();
        t_abort();
        test_done();
    end
endmodule : uartx_tx_sync_bench
